/* core/wwd_pkg.sv */
// package: register map, fields, reset values and timing of the window watchdog
package wwd_pkg;

    // ==========================================================
    // register map (word index; byte address is four times it)
    localparam logic [9:0] BASE_BLOCK_IDX    = 10'h200;
    localparam logic [9:0] BASE_NONBLOCK_IDX = 10'h300;
    localparam logic [9:0] CFG_OFFSET_IDX    = 10'h010;
    localparam logic [9:0] SVC_OFFSET_IDX    = 10'h011;
    localparam int         ADDR_W            = 12;

    // ==========================================================
    // field positions and reset values
    localparam int         OFF_FLAG_BIT  = 7;
    localparam int         WIN_FLAG_BIT  = 6;
    localparam int         SEL_LSB       = 0;
    localparam int         SEL_W         = 3;
    localparam logic [7:0] CFG_RESET     = 8'h00;
    localparam logic [7:0] SVC_RESET     = 8'h55;
    localparam logic [7:0] KEY_FIRST     = 8'hAA;
    localparam logic [7:0] KEY_SECOND    = 8'h55;

    // ==========================================================
    // timing: base step of the timeout ladder is 10 ms
    localparam int UNIT_TIMEOUT_MS  = 10;
    localparam int CLK_MHZ          = 250;
    localparam int UNIT_CYCLES      = UNIT_TIMEOUT_MS * CLK_MHZ * 1000;
    // fixed timeout of the initial non-window phase
    localparam int INIT_TIMEOUT_MS  = 10;
    localparam int INIT_CYCLES      = INIT_TIMEOUT_MS * CLK_MHZ * 1000;

    // ==========================================================
    // operating states of the watchdog
    typedef enum logic [1:0] {
        WWD_INIT     = 2'b00,
        WWD_WINDOW   = 2'b01,
        WWD_DISABLED = 2'b10
    } wwd_state_t;

    // software-visible configuration/status byte
    typedef struct packed {
        logic       offFlag;
        logic       winFlag;
        logic [2:0] zero;
        logic [2:0] timeoutSel;
    } wwd_cfg_t;

endpackage : wwd_pkg

/* core/wwd_window_watchdog.sv */
// window watchdog with its configuration and service registers on APB
`timescale 1ns/1ns

module wwd_window_watchdog #(
    parameter int UNIT_CYCLES = wwd_pkg::UNIT_CYCLES,
    parameter int INIT_CYCLES = wwd_pkg::INIT_CYCLES
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst_b,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [wwd_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      extDisable,
    input  wire logic                      lowPower,
    output logic                           wdReset
);
    import wwd_pkg::*;

    // ==========================================================
    // parameter check; the ladder shifts by up to 7 within 32 bits
    if (UNIT_CYCLES < 2 || UNIT_CYCLES >= (1 << 24) ||
        INIT_CYCLES < 2) begin : g_bad_cycles
        $error("wwd_window_watchdog: timeout cycle counts out of range");
    end

    // ==========================================================
    // state
    wwd_state_t  state;
    wwd_state_t  next_state;
    logic [31:0] count;
    logic [31:0] next_count;
    logic [2:0]  timeoutSel;
    logic [2:0]  next_timeoutSel;
    logic [7:0]  svcKey;
    logic [7:0]  next_svcKey;
    logic [7:0]  expectKey;
    logic [7:0]  next_expectKey;
    logic        next_wdReset;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    // ==========================================================
    // address decode
    logic [9:0]  wordIdx;
    logic        baseHit;
    logic        hitCfg;
    logic        hitSvc;
    logic        busDone;
    logic        wrCfg;
    logic        wrSvc;
    logic        rdCfg;

    assign wordIdx = paddr[ADDR_W-1:2];
    // both aliases decode to the same registers
    assign baseHit = (paddr[1:0] == 2'h0) &&
                     ((wordIdx[9:8] == BASE_BLOCK_IDX[9:8]) ||
                      (wordIdx[9:8] == BASE_NONBLOCK_IDX[9:8])) &&
                     (wordIdx[7:5] == 3'h0);
    assign hitCfg  = baseHit && (wordIdx[4:0] == CFG_OFFSET_IDX[4:0]);
    assign hitSvc  = baseHit && (wordIdx[4:0] == SVC_OFFSET_IDX[4:0]);
    // a write takes effect on the edge that samples pready high
    assign busDone = psel && penable && pready;
    assign wrCfg   = busDone && pwrite && hitCfg && pstrb[0];
    assign wrSvc   = busDone && pwrite && hitSvc && pstrb[0];
    assign rdCfg   = psel && penable && !pready && !pwrite && hitCfg;

    // ==========================================================
    // timeout length and window
    logic [31:0] limit;
    logic [31:0] curLimit;
    logic        winOpen;
    logic        timedOut;

    // doubling ladder; code 110 falls out as 640 ms
    assign limit    = 32'(UNIT_CYCLES) << timeoutSel;
    // initial phase ignores the selector and runs its fixed length
    assign curLimit = (state == WWD_INIT) ? 32'(INIT_CYCLES) : limit;
    // window closed for the first half, open for the second
    assign winOpen  = (state == WWD_INIT) ||
                      ((state == WWD_WINDOW) &&
                       (count >= (limit >> 1)));
    assign timedOut = (state != WWD_DISABLED) && !lowPower &&
                      (count >= curLimit - 32'h1);

    // ==========================================================
    // watchdog next state
    always_comb begin
        next_state      = state;
        next_count      = count;
        next_svcKey     = svcKey;
        next_expectKey  = expectKey;
        next_timeoutSel = timeoutSel;
        next_wdReset    = 1'b0;
        if (wrCfg) begin
            next_timeoutSel = pwdata[SEL_LSB +: SEL_W];
        end
        case (state)
            WWD_DISABLED: begin
                // re-enable must run the initial sequence again
                next_state = WWD_INIT;
            end
            WWD_INIT, WWD_WINDOW: begin
                if (lowPower) begin
                    // counter frozen, service byte back to default
                    next_svcKey = SVC_RESET;
                end else if (wrSvc) begin
                    next_svcKey = pwdata[7:0];
                    if (pwdata[7:0] != expectKey || !winOpen) begin
                        next_wdReset = 1'b1;
                    end else begin
                        // good key in an open window restarts
                        next_count     = 32'h0;
                        next_state     = WWD_WINDOW;
                        next_expectKey = (expectKey == KEY_FIRST) ?
                                         KEY_SECOND : KEY_FIRST;
                    end
                end else if (timedOut) begin
                    next_wdReset = 1'b1;
                end else begin
                    next_count = count + 32'h1;
                end
            end
            default: begin
                next_state = WWD_INIT;
            end
        endcase
        // a fired reset restarts the initial phase
        if (next_wdReset) begin
            next_state     = WWD_INIT;
            next_count     = 32'h0;
            next_svcKey    = SVC_RESET;
            next_expectKey = KEY_FIRST;
        end
        // external disable overrides the watchdog state, service writes are lost, config writes still land
        if (extDisable) begin
            next_state     = WWD_DISABLED;
            next_count     = 32'h0;
            next_svcKey    = SVC_RESET;
            next_expectKey = KEY_FIRST;
            next_wdReset   = 1'b0;
        end
    end

    // ==========================================================
    // bus answer: one wait state, data and error registered
    always_comb begin
        next_pready  = psel && penable && !pready;
        next_pslverr = 1'b0;
        next_prdata  = 32'h0;
        if (psel && penable && !pready) begin
            if (hitCfg) begin
                next_prdata[OFF_FLAG_BIT] = (state == WWD_DISABLED) ||
                                            extDisable;
                next_prdata[WIN_FLAG_BIT] = winOpen;
                next_prdata[SEL_LSB +: SEL_W] = timeoutSel;
            end else if (hitSvc) begin
                next_prdata[7:0] = svcKey;
            end else begin
                // unmapped words answer with an error
                next_pslverr = 1'b1;
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state      <= WWD_INIT;
            count      <= 32'h0;
            timeoutSel <= CFG_RESET[SEL_LSB +: SEL_W];
            svcKey     <= SVC_RESET;
            expectKey  <= KEY_FIRST;
            wdReset    <= 1'b0;
            prdata     <= 32'h0;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end else begin
            state      <= next_state;
            count      <= next_count;
            timeoutSel <= next_timeoutSel;
            svcKey     <= next_svcKey;
            expectKey  <= next_expectKey;
            wdReset    <= next_wdReset;
            prdata     <= next_prdata;
            pready     <= next_pready;
            pslverr    <= next_pslverr;
        end
    end

    // ==========================================================
    // checks
    logic liveSvc;
    assign liveSvc = wrSvc && !extDisable && !lowPower &&
                     (state != WWD_DISABLED);

    a_timeout_fires: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (state == WWD_WINDOW && !extDisable && !lowPower && !wrSvc &&
         count == limit - 32'h1) |=> wdReset && state == WWD_INIT)
        else $error("timeout did not raise watchdog reset");

    a_wrong_key: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (liveSvc && pwdata[7:0] != expectKey) |=> wdReset)
        else $error("wrong service key did not reset");

    a_closed_window: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (liveSvc && state == WWD_WINDOW && count < (limit >> 1))
        |=> wdReset)
        else $error("service in closed window accepted");

    a_good_restart: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (liveSvc && winOpen && pwdata[7:0] == expectKey)
        |=> count == 32'h0 && !wdReset &&
            expectKey != $past(expectKey) && state == WWD_WINDOW)
        else $error("valid service did not restart counter");

    a_first_key_aa: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (state == WWD_INIT) |-> expectKey == KEY_FIRST)
        else $error("initial phase expects other than first key");

    a_disable_ignores: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        extDisable [*2] |-> state == WWD_DISABLED && count == 32'h0 &&
                            svcKey == SVC_RESET && !wdReset)
        else $error("disabled watchdog reacted");

    a_lowpower_halt: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (lowPower && !extDisable && state != WWD_DISABLED)
        |=> count == $past(count) && svcKey == SVC_RESET)
        else $error("low power did not halt watchdog");

    a_cfg_flags: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        rdCfg |=> prdata[OFF_FLAG_BIT] == ($past(extDisable) ||
                  $past(state) == WWD_DISABLED) &&
                  prdata[WIN_FLAG_BIT] == $past(winOpen) && pready)
        else $error("config read shows wrong flags");

    a_unmapped_err: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (psel && penable && !pready && !hitCfg && !hitSvc)
        |=> pready && pslverr)
        else $error("unmapped access not refused");

    a_init_timeout: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (state == WWD_INIT && !extDisable && !lowPower && !wrSvc &&
         count == 32'(INIT_CYCLES) - 32'h1) |=> wdReset)
        else $error("initial timeout did not raise watchdog reset");

    a_reset_restarts: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        wdReset |-> state == WWD_INIT && count == 32'h0 &&
                    expectKey == KEY_FIRST && svcKey == SVC_RESET)
        else $error("watchdog reset did not restart initial phase");

    a_sel_readback: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        rdCfg |=> prdata[SEL_LSB +: SEL_W] == $past(timeoutSel) &&
                  prdata[5:3] == 3'h0)
        else $error("config read shows wrong selector");

    a_long_codes: assert property (
        @(posedge sys_clk) disable iff (!rst_b)
        (timeoutSel == 3'h6) |-> limit == 32'(UNIT_CYCLES) * 32'h40)
        else $error("selector code 110 does not give 64 units");

    c_restart: cover property (
        @(posedge sys_clk) disable iff (!rst_b)
        liveSvc && state == WWD_WINDOW && winOpen);
    c_timeout: cover property (
        @(posedge sys_clk) disable iff (!rst_b)
        timedOut && state == WWD_WINDOW);
    c_reenable: cover property (
        @(posedge sys_clk) disable iff (!rst_b)
        state == WWD_DISABLED ##1 state == WWD_INIT);
    c_wrong_key: cover property (
        @(posedge sys_clk) disable iff (!rst_b)
        liveSvc && pwdata[7:0] != expectKey);
    c_lowpower: cover property (
        @(posedge sys_clk) disable iff (!rst_b)
        lowPower && state == WWD_WINDOW);

endmodule : wwd_window_watchdog

/* testbench/wwd_apb_master.sv */
// partner model: apb master standing in for the controller software
`timescale 1ns/1ns
module wwd_apb_master (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        reqGo,
    input  wire logic        reqWrite,
    input  wire logic [11:0] reqAddr,
    input  wire logic [31:0] reqData,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb,
    output logic             done,
    output logic             rdErr,
    output logic      [31:0] rdData
);
    // ==========================================================
    // transfer sequencing
    assign pstrb = 4'hF; // byte lane 0 always enabled

    // setup, then access held until pready is seen high
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            pwrite  <= 1'b0;
            paddr   <= 12'h000;
            pwdata  <= 32'h0;
            done    <= 1'b0;
            rdErr   <= 1'b0;
            rdData  <= 32'h0;
        end else begin
            done <= 1'b0;
            if (!psel && reqGo) begin
                psel   <= 1'b1;
                pwrite <= reqWrite;
                paddr  <= reqAddr;
                pwdata <= reqData;
            end else if (psel && !penable) begin
                penable <= 1'b1;
            end else if (psel && pready) begin
                psel    <= 1'b0;
                penable <= 1'b0;
                pwdata  <= ~pwdata; // released bus must not look valid
                done    <= 1'b1;
                rdErr   <= pslverr;
                rdData  <= prdata;
            end
        end
    end
endmodule : wwd_apb_master

/* testbench/window_watchdog_control_tb_top.sv */
// testbench: register map, key sequence and reset behaviour of the watchdog
`timescale 1ns/1ns
module window_watchdog_control_tb_top;
    import wwd_pkg::*;
    localparam logic [11:0] CFG  = {BASE_BLOCK_IDX + CFG_OFFSET_IDX, 2'b00};
    localparam logic [11:0] SVC  = {BASE_BLOCK_IDX + SVC_OFFSET_IDX, 2'b00};
    localparam logic [11:0] CFGN = {BASE_NONBLOCK_IDX + CFG_OFFSET_IDX, 2'b00};
    localparam logic [11:0] SVCN = {BASE_NONBLOCK_IDX + SVC_OFFSET_IDX, 2'b00};
    localparam logic [31:0] KA   = {24'h0, KEY_FIRST};
    localparam logic [31:0] KB   = {24'h0, KEY_SECOND};
    typedef struct packed {
        logic        w;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic        err;
    } wwd_row_t;
    logic        sys_clk, rst_b, reqGo, reqWrite, done, rdErr;
    logic        psel, penable, pwrite, pready, pslverr;
    logic        extDisable, lowPower, wdReset;
    logic [11:0] reqAddr, paddr;
    logic [31:0] reqData, pwdata, prdata, rdData;
    logic [3:0]  pstrb;
    int          errors = 0, totalChecks = 0, resets = 0, cyc = 0;
    // initial phase keeps the window flag set
    wwd_row_t rows[8] = '{
        '{1'b0, CFG, 32'h0, 32'h40, 1'b0}, '{1'b0, SVC, 32'h0, 32'h55, 1'b0},
        '{1'b1, CFG, 32'hFFFFFFC5, 32'h0, 1'b0},
        '{1'b0, CFGN, 32'h0, 32'h45, 1'b0}, '{1'b1, CFGN, 32'h6, 32'h0, 1'b0},
        '{1'b0, SVCN, 32'h0, 32'h55, 1'b0},
        '{1'b0, 12'h848, 32'h0, 32'h0, 1'b1},
        '{1'b0, 12'h841, 32'h0, 32'h0, 1'b1}};

    // ==========================================================
    // design and partner
    wwd_window_watchdog #(.UNIT_CYCLES(16), .INIT_CYCLES(32)) i_dut (
        .sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .extDisable, .lowPower, .wdReset);
    wwd_apb_master i_master (
        .sys_clk, .rst_b, .reqGo, .reqWrite, .reqAddr, .reqData, .pready,
        .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .done, .rdErr, .rdData);

    // ==========================================================
    // clock, reset pulse counter and hang guard
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (wdReset === 1'b1) resets++;
        if (cyc == 4000) begin
            errors++;
            report_and_stop();
        end
    end

    // ==========================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one whole apb transfer; ends on a clock edge
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        reqWrite <= w;
        reqAddr  <= a;
        reqData  <= d;
        reqGo    <= 1'b1;
        @(posedge sys_clk);
        reqGo <= 1'b0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (done !== 1'b1 && n < 50);
        if (n >= 50) errors++;
    endtask : xfer
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rdData, e);
    endtask : rd
    task automatic pause(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : pause
    task automatic report_and_stop();
        $display("checks %0d errors %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // main sequence
    initial begin
        rst_b = 1'b0;
        reqGo = 1'b0;
        reqWrite = 1'b0;
        reqAddr = 12'h000;
        reqData = 32'h0;
        extDisable = 1'b0;
        lowPower = 1'b0;
        pause(12);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            xfer(rows[i].w, rows[i].a, rows[i].d);
            chk({31'h0, rdErr}, {31'h0, rows[i].err});
            if (!rows[i].w) chk(rdData, rows[i].e);
        end
        for (int s = 0; s < 8; s++) begin
            xfer(1'b1, CFG, 32'(s));
            rd(CFG, 32'h40 | 32'(s));
        end
        // second reset mid-run, then window service with selector 1
        rst_b <= 1'b0;
        pause(12);
        rst_b <= 1'b1;
        resets = 0;
        @(posedge sys_clk);
        xfer(1'b1, CFG, 32'h1);
        xfer(1'b1, SVC, KA);
        rd(CFG, 32'h01);
        pause(12);
        rd(CFG, 32'h41);
        xfer(1'b1, SVC, KB);
        rd(SVC, KB);
        pause(14);
        xfer(1'b1, SVC, KB); // repeated key in open window
        pause(2);
        chk(32'(resets), 32'h1);
        rd(SVC, 32'h55);
        // second key written while the window is still closed
        xfer(1'b1, SVC, KA);
        xfer(1'b1, SVC, KB);
        pause(2);
        chk(32'(resets), 32'h2);
        pause(26);
        chk(32'(resets), 32'h2);
        pause(10);
        chk(32'(resets), 32'h3);
        xfer(1'b1, SVC, KA);
        pause(26);
        chk(32'(resets), 32'h3);
        pause(10);
        chk(32'(resets), 32'h4);
        // external disable, then low power
        extDisable <= 1'b1;
        pause(2);
        xfer(1'b0, CFG, 32'h0);
        chk(rdData & 32'h80, 32'h80);
        xfer(1'b1, SVC, KA);
        rd(SVC, 32'h55);
        pause(80);
        chk(32'(resets), 32'h4);
        extDisable <= 1'b0;
        pause(2);
        xfer(1'b1, SVC, KA);
        lowPower <= 1'b1;
        pause(2);
        rd(SVC, 32'h55);
        pause(80);
        chk(32'(resets), 32'h4);
        lowPower <= 1'b0;
        // code 110: 64 units, 1024 cycles here, from the frozen count
        xfer(1'b1, CFG, 32'h6);
        pause(1010);
        chk(32'(resets), 32'h4);
        pause(15);
        chk(32'(resets), 32'h5);
        report_and_stop();
    end
endmodule : window_watchdog_control_tb_top
